// ---- design/identify_geometry.sv ----
// Identification geometry words behind an APB register slave.
//
// Contract
// - Capacity is classed against 1,032,192 and 16,515,072 sector thresholds.
// - Small drives report default cylinders of at most 1,024.
// - Mid drives cap default cylinders by head count: 65,535, 32,767, 16,383.
// - Default heads never exceed 16.
// - Default sectors per track never exceed 63 up to the large limit.
// - Default cylinder, head and sector words are constants.
// - Current translation words 53 to 58 are always provided.
// - Word 53 bit 0 is one while the current translation is valid.
// - Unsupported translation clears word 53 bit 0 and zeroes words 54 to 58.
// - Before any geometry command current cylinders equal default cylinders.
// - After a geometry command cylinders are sectors over heads times sectors, saturated.
// - Current heads come from the last geometry command, else default heads.
// - Current sectors come from the last geometry command, else default sectors.
// - Words 57 and 58 hold cylinders times heads times sectors.
// - CHS capacity never exceeds a nonzero LBA capacity.
// - Words 60 and 61 report the constant total user sector count.
// - Drives above the small limit should support logical block addressing.
// - The device may permit or refuse CHS access to orphan sectors.
// - Defaults should keep orphan sectors below heads times sectors.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "geometry_cfg.svh"
module identify_geometry #(
   parameter logic [15:0] DEF_CYL = 16'h3FFF,
   parameter logic [4:0] DEF_HEADS = 5'h10,
   parameter logic [7:0] DEF_SECT = 8'h3F,
   parameter logic [31:0] LBA_SECTORS = 32'h00FB_FC10
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire geometry_pkg::apb_req_t apb_req,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   output logic orphan_chs_allow,
   output logic busy
);
   // Capacity class selects the limits on the default words.
   localparam logic is_small = (LBA_SECTORS <= `GEO_SMALL_LIMIT);
   localparam logic is_mid = !is_small && (LBA_SECTORS <= `GEO_LARGE_LIMIT);
   localparam logic [4:0] def_heads_c = (DEF_HEADS > `GEO_HEADS_MAX) ?
      `GEO_HEADS_MAX : DEF_HEADS;
   localparam logic [7:0] def_sect_c = (!is_small && !is_mid) ? DEF_SECT :
      ((DEF_SECT > `GEO_SECT_MAX) ? `GEO_SECT_MAX : DEF_SECT);
   localparam logic [15:0] cyl_cap = is_small ? `GEO_SMALL_CYL_MAX :
      !is_mid ? `GEO_CYL_MAX_4H :
      (def_heads_c <= 5'h04) ? `GEO_CYL_MAX_4H :
      (def_heads_c <= 5'h08) ? `GEO_CYL_MAX_8H : `GEO_CYL_MAX_16H;
   localparam logic [15:0] def_cyl_c = (DEF_CYL > cyl_cap) ? cyl_cap : DEF_CYL;

   geometry_pkg::geo_regs_t r_q;
   geometry_pkg::geo_regs_t r_d;
   logic [31:0] chs_cap;
   logic setup;
   logic access;
   logic [12:0] rem_shift;
   logic [31:0] rd_word;
   logic rd_hit;
   logic [4:0] new_heads;
   logic [7:0] new_sect;

   // Words 57 and 58 are always the product of the current words.
   assign chs_cap = 32'(r_q.cyl) * 32'(r_q.heads) * 32'(r_q.sect);
   assign setup = apb_req.psel && !apb_req.penable;
   assign access = apb_req.psel && apb_req.penable;
   assign pready = access;
   assign prdata = r_q.rdata;
   assign pslverr = access && r_q.err;
   assign orphan_chs_allow = r_q.orphan_allow;
   assign busy = (r_q.state != geometry_pkg::st_idle);
   assign new_heads = apb_req.pwdata[`GEO_INIT_HEADS_LSB +: 5];
   assign new_sect = apb_req.pwdata[`GEO_INIT_SECT_LSB +: 8];
   assign rem_shift = {r_q.rem[11:0], r_q.quo[31]};

   // Read decode; the LBA word pair keeps its low half at the lower word.
   always_comb begin
      rd_hit = 1'b1;
      rd_word = 32'h0000_0000;
      if (apb_req.paddr == `GEO_OFF_W1) begin
         rd_word = {16'h0000, def_cyl_c};
      end else if (apb_req.paddr == `GEO_OFF_W3) begin
         rd_word = {27'h000_0000, def_heads_c};
      end else if (apb_req.paddr == `GEO_OFF_W6) begin
         rd_word = {24'h00_0000, def_sect_c};
      end else if (apb_req.paddr == `GEO_OFF_W53) begin
         rd_word = {31'h0000_0000, r_q.valid};
      end else if (apb_req.paddr == `GEO_OFF_W54) begin
         rd_word = {16'h0000, r_q.cyl};
      end else if (apb_req.paddr == `GEO_OFF_W55) begin
         rd_word = {27'h000_0000, r_q.heads};
      end else if (apb_req.paddr == `GEO_OFF_W56) begin
         rd_word = {24'h00_0000, r_q.sect};
      end else if (apb_req.paddr == `GEO_OFF_W57) begin
         rd_word = {16'h0000, chs_cap[15:0]};
      end else if (apb_req.paddr == `GEO_OFF_W58) begin
         rd_word = {16'h0000, chs_cap[31:16]};
      end else if (apb_req.paddr == `GEO_OFF_W60) begin
         rd_word = {16'h0000, LBA_SECTORS[15:0]};
      end else if (apb_req.paddr == `GEO_OFF_W61) begin
         rd_word = {16'h0000, LBA_SECTORS[31:16]};
      end else if (apb_req.paddr == `GEO_OFF_CTRL) begin
         rd_word = {31'h0000_0000, r_q.orphan_allow};
      end else if (apb_req.paddr == `GEO_OFF_INIT) begin
         rd_word = {16'h0000, r_q.sect, 3'h0, r_q.heads};
      end else if (apb_req.paddr == `GEO_OFF_STAT) begin
         rd_word = {29'h0000_0000, r_q.valid, r_q.inited, busy};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Next state: bus capture, geometry command, and a restoring divider.
   always_comb begin
      r_d = r_q;
      if (setup) begin
         r_d.rdata = apb_req.pwrite ? 32'h0000_0000 : rd_word;
         r_d.err = !rd_hit || (apb_req.pwrite && apb_req.paddr == `GEO_OFF_INIT && busy);
      end
      if (access && apb_req.pwrite && !r_q.err) begin
         if (apb_req.paddr == `GEO_OFF_CTRL) begin
            r_d.orphan_allow = apb_req.pwdata[`GEO_CTRL_ORPHAN];
         end else if (apb_req.paddr == `GEO_OFF_INIT) begin
            r_d.inited = 1'b1;
            if (new_heads == 5'h00 || new_heads > `GEO_HEADS_MAX || new_sect == 8'h00) begin
               r_d.valid = 1'b0;
               r_d.cyl = 16'h0000;
               r_d.heads = 5'h00;
               r_d.sect = 8'h00;
            end else begin
               r_d.valid = 1'b0;
               r_d.heads = new_heads;
               r_d.sect = new_sect;
               r_d.cyl = 16'h0000;
               r_d.divisor = 12'(new_heads) * 12'(new_sect);
               r_d.quo = LBA_SECTORS;
               r_d.rem = 13'h0000;
               r_d.cnt = `GEO_DIV_STEPS;
               r_d.state = geometry_pkg::st_divide;
            end
         end
      end
      case (r_q.state)
         geometry_pkg::st_divide: begin
            if (rem_shift >= {1'b0, r_q.divisor}) begin
               r_d.rem = rem_shift - {1'b0, r_q.divisor};
               r_d.quo = {r_q.quo[30:0], 1'b1};
            end else begin
               r_d.rem = rem_shift;
               r_d.quo = {r_q.quo[30:0], 1'b0};
            end
            r_d.cnt = r_q.cnt - 6'h01;
            if (r_q.cnt == 6'h01) begin
               r_d.state = geometry_pkg::st_finish;
            end
         end
         geometry_pkg::st_finish: begin
            // Saturation keeps the product below the LBA count as well.
            r_d.cyl = (r_q.quo > `GEO_CYL_SAT) ? 16'hFFFF : r_q.quo[15:0];
            r_d.valid = 1'b1;
            r_d.state = geometry_pkg::st_idle;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         r_q <= '0;
         r_q.state <= geometry_pkg::st_idle;
         r_q.valid <= 1'b1;
         r_q.cyl <= def_cyl_c;
         r_q.heads <= def_heads_c;
         r_q.sect <= def_sect_c;
         r_q.orphan_allow <= `GEO_RST_ORPHAN;
      end else begin
         r_q <= r_d;
      end
   end

   a_cap_product: assert property (@(posedge ref_clk) disable iff (reset)
      access && !apb_req.pwrite && apb_req.paddr == `GEO_OFF_W57 && $past(setup)
      |-> prdata[15:0] == chs_cap[15:0])
      else $error("Low capacity word differs from the product.");
   a_cap_below_lba: assert property (@(posedge ref_clk) disable iff (reset)
      LBA_SECTORS != 32'h0000_0000 |-> chs_cap <= LBA_SECTORS)
      else $error("CHS capacity exceeds LBA capacity.");
   a_default_cyl: assert property (@(posedge ref_clk) disable iff (reset)
      !r_q.inited |-> r_q.cyl == def_cyl_c && r_q.valid)
      else $error("Current cylinders differ from default before a command.");
   a_bad_clears: assert property (@(posedge ref_clk) disable iff (reset)
      access && apb_req.pwrite && apb_req.paddr == `GEO_OFF_INIT && !r_q.err
      && new_sect == 8'h00 |=> !r_q.valid && chs_cap == 32'h0000_0000
      && r_q.heads == 5'h00 && r_q.cyl == 16'h0000)
      else $error("Unsupported translation left words set.");
   a_div_result: assert property (@(posedge ref_clk) disable iff (reset)
      r_q.state == geometry_pkg::st_finish |=> r_q.valid
      && 32'(r_q.cyl) == (($past(r_q.quo) > `GEO_CYL_SAT) ? `GEO_CYL_SAT : $past(r_q.quo)))
      else $error("Current cylinders not saturated quotient.");
   a_div_length: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(busy) |-> ##33 !busy && r_q.valid)
      else $error("Geometry computation took the wrong time.");
   a_head_range: assert property (@(posedge ref_clk) disable iff (reset)
      r_q.valid |-> r_q.heads >= 5'h01 && r_q.heads <= `GEO_HEADS_MAX && r_q.sect != 8'h00)
      else $error("Valid translation with out of range heads or sectors.");
   a_default_limits: assert property (@(posedge ref_clk) disable iff (reset)
      def_heads_c <= `GEO_HEADS_MAX && def_cyl_c <= cyl_cap
      && (is_small || !is_mid || def_sect_c <= `GEO_SECT_MAX))
      else $error("Default geometry outside its limits.");
   a_lba_words: assert property (@(posedge ref_clk) disable iff (reset)
      access && !apb_req.pwrite && apb_req.paddr == `GEO_OFF_W61 && $past(setup)
      |-> prdata[15:0] == LBA_SECTORS[31:16])
      else $error("High LBA word wrong.");
   a_orphans_few: assert property (@(posedge ref_clk) disable iff (reset)
      !r_q.inited |-> LBA_SECTORS - chs_cap < 32'(r_q.heads) * 32'(r_q.sect))
      else $error("Default geometry leaves too many orphan sectors.");
   a_apb_answer: assert property (@(posedge ref_clk) disable iff (reset)
      setup |=> pready)
      else $error("Access phase without ready.");

   // The first edge after reset shows the clamped default translation.
   a_reset_values: assert property (@(posedge ref_clk)
      $fell(reset) |-> r_q.valid && r_q.cyl == def_cyl_c && r_q.heads == def_heads_c
      && r_q.sect == def_sect_c && !busy)
      else $error("Translation after reset differs from the defaults.");

   // Word 1 always reads the clamped default cylinder count.
   a_word1_read: assert property (@(posedge ref_clk) disable iff (reset)
      access && !apb_req.pwrite && apb_req.paddr == `GEO_OFF_W1
      |-> prdata == {16'h0000, def_cyl_c})
      else $error("Default cylinder word changed.");

   // Word 3 always reads the clamped default head count.
   a_word3_read: assert property (@(posedge ref_clk) disable iff (reset)
      access && !apb_req.pwrite && apb_req.paddr == `GEO_OFF_W3
      |-> prdata == {27'h000_0000, def_heads_c})
      else $error("Default head word changed.");

   // Word 6 always reads the clamped default sector count.
   a_word6_read: assert property (@(posedge ref_clk) disable iff (reset)
      access && !apb_req.pwrite && apb_req.paddr == `GEO_OFF_W6
      |-> prdata == {24'h00_0000, def_sect_c})
      else $error("Default sector word changed.");

   // Word 60 carries the low half of the LBA count.
   a_word60_read: assert property (@(posedge ref_clk) disable iff (reset)
      access && !apb_req.pwrite && apb_req.paddr == `GEO_OFF_W60
      |-> prdata == {16'h0000, LBA_SECTORS[15:0]})
      else $error("Low LBA word wrong.");

   // Word 53 shows the valid flag as it stood in the setup cycle.
   a_word53_read: assert property (@(posedge ref_clk) disable iff (reset)
      access && !apb_req.pwrite && apb_req.paddr == `GEO_OFF_W53 && $past(setup)
      |-> prdata == {31'h0000_0000, $past(r_q.valid)})
      else $error("Valid flag word wrong.");

   // Word 54 shows the current cylinders as they stood in the setup cycle.
   a_word54_read: assert property (@(posedge ref_clk) disable iff (reset)
      access && !apb_req.pwrite && apb_req.paddr == `GEO_OFF_W54 && $past(setup)
      |-> prdata == {16'h0000, $past(r_q.cyl)})
      else $error("Current cylinder word wrong.");

   // Word 55 shows the current heads as they stood in the setup cycle.
   a_word55_read: assert property (@(posedge ref_clk) disable iff (reset)
      access && !apb_req.pwrite && apb_req.paddr == `GEO_OFF_W55 && $past(setup)
      |-> prdata == {27'h000_0000, $past(r_q.heads)})
      else $error("Current head word wrong.");

   // Word 56 shows the current sectors as they stood in the setup cycle.
   a_word56_read: assert property (@(posedge ref_clk) disable iff (reset)
      access && !apb_req.pwrite && apb_req.paddr == `GEO_OFF_W56 && $past(setup)
      |-> prdata == {24'h00_0000, $past(r_q.sect)})
      else $error("Current sector word wrong.");

   // Word 58 carries the high half of the CHS capacity.
   a_word58_read: assert property (@(posedge ref_clk) disable iff (reset)
      access && !apb_req.pwrite && apb_req.paddr == `GEO_OFF_W58 && $past(setup)
      |-> prdata[15:0] == $past(chs_cap[31:16]))
      else $error("High capacity word wrong.");

   // The status word reports busy, command seen and valid flag.
   a_stat_read: assert property (@(posedge ref_clk) disable iff (reset)
      access && !apb_req.pwrite && apb_req.paddr == `GEO_OFF_STAT && $past(setup)
      |-> prdata[2:0] == {$past(r_q.valid), $past(r_q.inited), $past(busy)})
      else $error("Status word wrong.");

   // A write returns zero read data.
   a_write_rdata_zero: assert property (@(posedge ref_clk) disable iff (reset)
      access && apb_req.pwrite |-> prdata == 32'h0000_0000)
      else $error("Read data not zero during a write.");

   // An address outside the map answers with an error.
   a_unmapped_err: assert property (@(posedge ref_clk) disable iff (reset)
      access && !rd_hit |-> pslverr)
      else $error("Unmapped address answered without error.");

   // A geometry command while busy is refused.
   a_busy_refuse: assert property (@(posedge ref_clk) disable iff (reset)
      setup && apb_req.pwrite && apb_req.paddr == `GEO_OFF_INIT && busy |=> pslverr)
      else $error("Geometry command while busy not refused.");

   // Ready and error stay low outside the access phase.
   a_ready_idle: assert property (@(posedge ref_clk) disable iff (reset)
      !access |-> !pready && !pslverr)
      else $error("Ready or error outside an access phase.");

   // An invalid translation at rest keeps words 54 to 58 at zero.
   a_invalid_zero: assert property (@(posedge ref_clk) disable iff (reset)
      !r_q.valid && !busy |-> r_q.cyl == 16'h0000 && r_q.heads == 5'h00
      && r_q.sect == 8'h00)
      else $error("Invalid translation left words set.");

   // A supported command starts the divider with the new heads and sectors.
   a_start_divide: assert property (@(posedge ref_clk) disable iff (reset)
      access && apb_req.pwrite && apb_req.paddr == `GEO_OFF_INIT && !r_q.err
      && new_heads != 5'h00 && new_heads <= `GEO_HEADS_MAX && new_sect != 8'h00
      |=> busy && !r_q.valid && r_q.cyl == 16'h0000 && r_q.heads == $past(new_heads)
      && r_q.sect == $past(new_sect))
      else $error("Geometry command did not start the computation.");

   // Current heads and sectors change only on a geometry command.
   a_heads_stable: assert property (@(posedge ref_clk) disable iff (reset)
      !(access && apb_req.pwrite && apb_req.paddr == `GEO_OFF_INIT)
      |=> $stable(r_q.heads) && $stable(r_q.sect))
      else $error("Current heads or sectors changed without a command.");

   // A control write sets the orphan access policy.
   a_orphan_write: assert property (@(posedge ref_clk) disable iff (reset)
      access && apb_req.pwrite && apb_req.paddr == `GEO_OFF_CTRL && !r_q.err
      |=> orphan_chs_allow == $past(apb_req.pwdata[`GEO_CTRL_ORPHAN]))
      else $error("Orphan policy not taken from the control write.");

   // The step counter stays inside its range while dividing.
   a_cnt_range: assert property (@(posedge ref_clk) disable iff (reset)
      r_q.state == geometry_pkg::st_divide
      |-> r_q.cnt >= 6'h01 && r_q.cnt <= `GEO_DIV_STEPS)
      else $error("Divider step count out of range.");

   // The valid flag is never set while the computation runs.
   a_valid_idle: assert property (@(posedge ref_clk) disable iff (reset)
      r_q.valid |-> !busy)
      else $error("Valid flag set during the computation.");

   c_init_ok: cover property (@(posedge ref_clk) disable iff (reset)
      r_q.state == geometry_pkg::st_finish);
   c_init_bad: cover property (@(posedge ref_clk) disable iff (reset)
      r_q.inited && !r_q.valid && !busy);
   c_saturate: cover property (@(posedge ref_clk) disable iff (reset)
      r_q.state == geometry_pkg::st_finish && r_q.quo > `GEO_CYL_SAT);
   c_busy_refuse: cover property (@(posedge ref_clk) disable iff (reset)
      pslverr && busy);
   c_back_to_back: cover property (@(posedge ref_clk) disable iff (reset)
      access ##1 access);
endmodule

// ---- design/geometry_cfg.svh ----
// Constants of the identification geometry block: offsets, limits, reset values and bit fields.
`ifndef GEOMETRY_CFG_SVH
`define GEOMETRY_CFG_SVH
`define GEO_SMALL_LIMIT 32'h000F_C000
`define GEO_LARGE_LIMIT 32'h00FC_0000
`define GEO_SMALL_CYL_MAX 16'h0400
`define GEO_CYL_MAX_4H 16'hFFFF
`define GEO_CYL_MAX_8H 16'h7FFF
`define GEO_CYL_MAX_16H 16'h3FFF
`define GEO_HEADS_MAX 5'h10
`define GEO_SECT_MAX 8'h3F
`define GEO_CUR_SECT_MAX 8'hFF
`define GEO_CYL_SAT 32'h0000_FFFF
`define GEO_DIV_STEPS 6'h20
`define GEO_OFF_W1 12'h004
`define GEO_OFF_W3 12'h00C
`define GEO_OFF_W6 12'h018
`define GEO_OFF_W53 12'h0D4
`define GEO_OFF_W54 12'h0D8
`define GEO_OFF_W55 12'h0DC
`define GEO_OFF_W56 12'h0E0
`define GEO_OFF_W57 12'h0E4
`define GEO_OFF_W58 12'h0E8
`define GEO_OFF_W60 12'h0F0
`define GEO_OFF_W61 12'h0F4
`define GEO_OFF_CTRL 12'h200
`define GEO_OFF_INIT 12'h204
`define GEO_OFF_STAT 12'h208
`define GEO_INIT_HEADS_LSB 0
`define GEO_INIT_SECT_LSB 8
`define GEO_STAT_BUSY 0
`define GEO_STAT_INITED 1
`define GEO_STAT_VALID 2
`define GEO_CTRL_ORPHAN 0
`define GEO_RST_ORPHAN 1'b0
`endif

// ---- design/geometry_pkg.sv ----
// Types shared by the identification geometry block.
package geometry_pkg;
   typedef enum logic [1:0] {st_idle, st_divide, st_finish} geo_state_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      geo_state_t state;
      logic inited;
      logic valid;
      logic orphan_allow;
      logic [15:0] cyl;
      logic [4:0] heads;
      logic [7:0] sect;
      logic [31:0] quo;
      logic [12:0] rem;
      logic [11:0] divisor;
      logic [5:0] cnt;
      logic [31:0] rdata;
      logic err;
   } geo_regs_t;
endpackage

// ---- verification/host_apb.sv ----
// Host model that reads and writes the geometry words over APB.
`timescale 1ns/100ps
module host_apb (
   input wire logic ref_clk,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   output geometry_pkg::apb_req_t apb_req
);
   initial begin
      apb_req = '0;
   end
   // One transfer: setup, access held until pready, then release with scrambled lines.
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic err, output logic lost);
      int n;
      n = 0;
      @(posedge ref_clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge ref_clk);
      apb_req.penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge ref_clk);
      end
      lost = (n >= 50);
      rd = prdata;
      err = pslverr;
      apb_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a, pwdata: ~wd};
   endtask
endmodule

// ---- verification/identify_geometry_tb.sv ----
// Self-checking testbench for the identification geometry words.
`timescale 1ns/100ps
module identify_geometry_tb;
   localparam int LBA = 32'h00FB_FC10;
   logic ref_clk, reset, pready, pslverr, orphan_chs_allow, busy, err, lost;
   logic [31:0] prdata, rd;
   geometry_pkg::apb_req_t apb_req;
   int fails, cmp_count, mh, ms, n;
   logic mv, mi;
   int th[6] = '{1, 16, 0, 17, 4, 16};
   int ts[6] = '{1, 255, 63, 63, 0, 63};
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   identify_geometry #(.DEF_CYL(16'h3FFF), .DEF_HEADS(5'h10), .DEF_SECT(8'h3F),
      .LBA_SECTORS(LBA)) dut_u (.ref_clk(ref_clk), .reset(reset), .apb_req(apb_req),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .orphan_chs_allow(orphan_chs_allow), .busy(busy));
   host_apb host_u (.ref_clk(ref_clk), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .apb_req(apb_req));
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      host_u.xfer(wr, a, wd, rd, err, lost);
      if (lost) begin
         fails++;
         conclude();
      end
   endtask
   task automatic word(input string name, input logic [11:0] a, input logic [31:0] exp,
         input logic [31:0] mask);
      acc(1'b0, a, 32'h0000_0000);
      chk(name, exp & mask, rd & mask);
   endtask
   task automatic check_all;
      longint c, chs;
      logic [15:0] lo;
      c = !mv ? 0 : !mi ? 16383 : (LBA / (mh * ms) > 65535 ? 65535 : LBA / (mh * ms));
      chs = mv ? c * mh * ms : 0;
      word("w1", 12'h004, 16383, 32'h0000_FFFF);
      word("w3", 12'h00C, 16, 32'h0000_FFFF);
      word("w6", 12'h018, 63, 32'h0000_FFFF);
      word("w53", 12'h0D4, {31'h0, mv}, 32'h0000_0001);
      word("w54", 12'h0D8, c, 32'h0000_FFFF);
      word("w55", 12'h0DC, mv ? mh : 0, 32'h0000_FFFF);
      word("w56", 12'h0E0, mv ? ms : 0, 32'h0000_FFFF);
      word("w57", 12'h0E4, chs[15:0], 32'h0000_FFFF);
      lo = rd[15:0];
      word("w58", 12'h0E8, chs[31:16], 32'h0000_FFFF);
      chk("chs_le_lba", 1, {31'h0, {rd[15:0], lo} <= LBA});
      word("w60", 12'h0F0, LBA & 32'hFFFF, 32'h0000_FFFF);
      word("w61", 12'h0F4, LBA >> 16, 32'h0000_FFFF);
      word("init_rd", 12'h204, mv ? ((ms << 8) | mh) : 0, 32'h0000_FFFF);
   endtask
   task automatic init(input int h, input int s, input logic second);
      acc(1'b1, 12'h204, {16'h0, s[7:0], 3'b0, h[4:0]});
      chk("init_err", 0, {31'h0, err});
      if (second) begin
         acc(1'b1, 12'h204, 32'h0000_0101);
         chk("busy_err", 1, {31'h0, err});
      end
      #1;
      n = 0;
      while (busy === 1'b1 && n < 100) begin
         n++;
         @(posedge ref_clk);
         #1;
      end
      if (n >= 100) begin
         fails++;
         conclude();
      end
      mv = h >= 1 && h <= 16 && s >= 1;
      if (mv) begin
         mi = 1'b1;
         mh = h;
         ms = s;
         if (!second) begin
            chk("busy_cycles", 33, n);
         end
      end
      check_all();
   endtask
   initial begin
      reset = 1'b1;
      fails = 0;
      cmp_count = 0;
      mv = 1'b1;
      mi = 1'b0;
      mh = 16;
      ms = 63;
      void'($urandom(77659));
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      chk("orphan_rst", 0, {31'h0, orphan_chs_allow});
      check_all();
      acc(1'b0, 12'h100, 32'h0000_0000);
      chk("unmapped_err", 1, {31'h0, err});
      chk("unmapped_data", 0, rd);
      for (int v = 1; v >= 0; v--) begin
         acc(1'b1, 12'h200, v);
         #1;
         chk("orphan_out", v, {31'h0, orphan_chs_allow});
      end
      foreach (th[i]) init(th[i], ts[i], 1'b0);
      for (int i = 0; i < 6; i++) init($urandom_range(16, 1), $urandom_range(255, 1), i == 2);
      conclude();
   end
endmodule
